// ---- tm_pkg.sv ----
// Shared types and constants for the execution-timing model of the unary,
// shift/rotate, single-bit and bit-field instruction groups.
// Assumes a single processor clock; the decoder supplies operation and form.
`default_nettype none

package tm_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int TM_CNT_W   = 6;   // Width of one table total.
  localparam int TM_BUS_W   = 2;   // Width of one bus-cycle count.
  localparam int TM_EA_W    = 8;   // Width of the added address time.
  localparam int TM_TOT_W   = 9;   // Table total plus address time.
  localparam int TM_FIELD_W = 32;  // Widest field, in bits.
  localparam logic [5:0] TM_WORD_BITS = 6'h20;  // Field width code 0 means this.

  // ----------------------------------------------------------------------
  // Operations, operand forms, added-time classes and table columns
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ZERO_OPERAND          = 5'b00000,
    OP_ARITH_INVERT_OP       = 5'b00001,
    OP_INVERT_WITH_CARRY_X   = 5'b00010,
    OP_BITWISE_NOT           = 5'b00011,
    OP_SIGN_WIDEN_OP         = 5'b00100,
    OP_DECIMAL_COMPLEMENT    = 5'b00101,
    OP_SET_ON_CONDITION      = 5'b00110,
    OP_TEST_AND_SET          = 5'b00111,
    OP_COMPARE_TO_ZERO       = 5'b01000,
    OP_LOGIC_SHIFT_LEFT      = 5'b01001,
    OP_LOGIC_SHIFT_RIGHT     = 5'b01010,
    OP_ARITH_SHIFT_LEFT      = 5'b01011,
    OP_ARITH_SHIFT_RIGHT     = 5'b01100,
    OP_ROTATE_LEFT           = 5'b01101,
    OP_ROTATE_RIGHT          = 5'b01110,
    OP_ROTATE_THROUGH_X_LEFT = 5'b01111,
    OP_ROTATE_THROUGH_X_RIGHT= 5'b10000,
    OP_SINGLE_BIT_PROBE      = 5'b10001,
    OP_SINGLE_BIT_TOGGLE     = 5'b10010,
    OP_SINGLE_BIT_ZERO       = 5'b10011,
    OP_SINGLE_BIT_FORCE_ONE  = 5'b10100,
    OP_FIELD_PROBE           = 5'b10101,
    OP_FIELD_TOGGLE          = 5'b10110,
    OP_FIELD_ZERO            = 5'b10111,
    OP_FIELD_FILL_ONES       = 5'b11000,
    OP_FIELD_EXTRACT_SIGNED  = 5'b11001,
    OP_FIELD_EXTRACT_UNSIGNED= 5'b11010,
    OP_FIELD_INSERT          = 5'b11011,
    OP_FIELD_FIND_FIRST_ONE  = 5'b11100
  } tm_op_t;

  // Register forms: static or immediate count, or register-held count or
  // bit number. Memory forms: storage operand, or immediate bit number.
  typedef enum logic [1:0] {
    FORM_REG_STATIC = 2'b00,
    FORM_REG_DYN    = 2'b01,
    FORM_MEM        = 2'b10,
    FORM_MEM_IMM    = 2'b11
  } tm_form_t;

  typedef enum logic [2:0] {
    ADD_NONE       = 3'b000,
    ADD_FETCH_EA   = 3'b001,
    ADD_CALC_EA    = 3'b010,
    ADD_FETCH_IMM  = 3'b011,
    ADD_CALC_IMM   = 3'b100
  } tm_add_t;

  typedef enum logic [1:0] {
    COL_BEST  = 2'b00,
    COL_CACHE = 2'b01,
    COL_WORST = 2'b10
  } tm_col_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } tm_state_t;

  // One table row: operand reads, writes and the three column totals.
  // Prefetch is one in the worst column and zero elsewhere for all rows here.
  typedef struct packed {
    logic [TM_BUS_W-1:0] rd;
    logic [TM_BUS_W-1:0] wr;
    logic [TM_CNT_W-1:0] best;
    logic [TM_CNT_W-1:0] cache;
    logic [TM_CNT_W-1:0] worst;
  } tm_entry_t;

  localparam logic [TM_BUS_W-1:0] TM_WORST_PREFETCH = 2'h1;

  function automatic tm_entry_t tm_mk(input int r, input int w, input int b,
                                      input int c, input int x);
    tm_entry_t e;
    e.rd    = TM_BUS_W'(r);
    e.wr    = TM_BUS_W'(w);
    e.best  = TM_CNT_W'(b);
    e.cache = TM_CNT_W'(c);
    e.worst = TM_CNT_W'(x);
    return e;
  endfunction : tm_mk

endpackage : tm_pkg

`default_nettype wire

// ---- tm_exec_timing.sv ----
// Execution-timing unit for unary, shift/rotate, single-bit and bit-field
// instructions: looks up the column total and bus-cycle triple, adds the
// externally computed address time where the form carries one, and then stays busy for that many cycles.
// Assumes the decoder holds its inputs stable in the cycle of i_start and
// that the address time is supplied already resolved by other logic.
`default_nettype none

module tm_exec_timing (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_sys_rst,
  input  wire logic                     i_start,
  input  wire tm_pkg::tm_op_t           i_op,
  input  wire tm_pkg::tm_form_t         i_form,
  input  wire logic                     i_overlapped,
  input  wire logic                     i_icache_hit,
  input  wire logic [2:0]               i_field_offset,
  input  wire logic [4:0]               i_field_width,
  input  wire logic [tm_pkg::TM_EA_W-1:0]  i_ea_cycles,
  output logic                          o_busy,
  output logic                          o_done,
  output logic                          o_bad_form,
  output logic [tm_pkg::TM_TOT_W-1:0]   o_total,
  output logic [tm_pkg::TM_BUS_W-1:0]   o_reads,
  output logic [tm_pkg::TM_BUS_W-1:0]   o_prefetches,
  output logic [tm_pkg::TM_BUS_W-1:0]   o_writes,
  output tm_pkg::tm_add_t               o_add_kind
);
  import tm_pkg::*;

  // ----------------------------------------------------------------------
  // Lookup functions
  // ----------------------------------------------------------------------

  // A field whose start offset plus width passes one longword needs a fifth
  // byte and therefore a second operand bus cycle.
  function automatic logic tm_five_bytes(input logic [2:0] off, input logic [4:0] wid);
    logic [5:0] w;
    logic [6:0] reach;
    w     = (wid == 5'h00) ? TM_WORD_BITS : {1'b0, wid};
    reach = {4'h0, off} + {1'b0, w};
    return reach > 7'(TM_FIELD_W);
  endfunction : tm_five_bytes

  // Picks register, short-memory or five-byte-memory row.
  function automatic tm_entry_t tm_sel3(input logic mem, input logic five,
                                        input tm_entry_t r, input tm_entry_t m4,
                                        input tm_entry_t m5);
    return !mem ? r : (five ? m5 : m4);
  endfunction : tm_sel3

  // Table rows. Shift amount is not an input: time never depends on it.
  function automatic tm_entry_t tm_lookup(input tm_op_t op, input tm_form_t f,
                                          input logic five);
    tm_entry_t e;
    logic      mem;
    mem = f[1];
    e   = tm_mk(0, 0, 0, 0, 0);
    unique case (op)
      OP_ZERO_OPERAND, OP_ARITH_INVERT_OP, OP_INVERT_WITH_CARRY_X, OP_BITWISE_NOT:
        e = mem ? tm_mk(0, 1, 3, 4, 6) : tm_mk(0, 0, 0, 2, 3);
      OP_SIGN_WIDEN_OP:          e = tm_mk(0, 0, 1, 4, 4);
      OP_DECIMAL_COMPLEMENT:     e = tm_mk(0, 0, 6, 6, 6);
      OP_SET_ON_CONDITION:
        e = mem ? tm_mk(0, 1, 6, 6, 6) : tm_mk(0, 0, 1, 4, 4);
      OP_TEST_AND_SET:
        e = mem ? tm_mk(1, 1, 12, 12, 13) : tm_mk(0, 0, 1, 4, 4);
      OP_COMPARE_TO_ZERO:        e = tm_mk(0, 0, 0, 2, 3);
      OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT:
        e = mem ? tm_mk(0, 1, 5, 5, 6)
                : ((f == FORM_REG_DYN) ? tm_mk(0, 0, 3, 6, 6) : tm_mk(0, 0, 1, 4, 4));
      OP_ARITH_SHIFT_LEFT:
        e = mem ? tm_mk(0, 1, 6, 6, 7) : tm_mk(0, 0, 5, 8, 8);
      OP_ARITH_SHIFT_RIGHT:
        e = mem ? tm_mk(0, 1, 5, 5, 6) : tm_mk(0, 0, 3, 6, 6);
      OP_ROTATE_LEFT, OP_ROTATE_RIGHT:
        e = mem ? tm_mk(0, 1, 7, 7, 7) : tm_mk(0, 0, 5, 8, 8);
      OP_ROTATE_THROUGH_X_LEFT, OP_ROTATE_THROUGH_X_RIGHT:
        e = mem ? tm_mk(0, 1, 5, 5, 6) : tm_mk(0, 0, 9, 12, 12);
      OP_SINGLE_BIT_PROBE:
        e = mem ? tm_mk(0, 0, 4, 4, 5) : tm_mk(0, 0, 1, 4, 5);
      OP_SINGLE_BIT_TOGGLE, OP_SINGLE_BIT_ZERO, OP_SINGLE_BIT_FORCE_ONE:
        e = mem ? tm_mk(0, 1, 4, 4, 5) : tm_mk(0, 0, 1, 4, 5);
      OP_FIELD_PROBE:
        e = tm_sel3(mem, five, tm_mk(0, 0, 3, 6, 7), tm_mk(1, 0, 11, 11, 12),
                    tm_mk(2, 0, 15, 15, 16));
      OP_FIELD_TOGGLE, OP_FIELD_ZERO, OP_FIELD_FILL_ONES:
        e = tm_sel3(mem, five, tm_mk(0, 0, 9, 12, 12), tm_mk(1, 1, 16, 16, 16),
                    tm_mk(2, 2, 24, 24, 24));
      OP_FIELD_EXTRACT_SIGNED, OP_FIELD_EXTRACT_UNSIGNED:
        e = tm_sel3(mem, five, tm_mk(0, 0, 5, 8, 8), tm_mk(1, 0, 13, 13, 13),
                    tm_mk(2, 0, 18, 18, 18));
      OP_FIELD_INSERT:
        e = tm_sel3(mem, five, tm_mk(0, 0, 7, 10, 10), tm_mk(1, 1, 14, 14, 15),
                    tm_mk(2, 2, 20, 20, 21));
      OP_FIELD_FIND_FIRST_ONE:
        e = tm_sel3(mem, five, tm_mk(0, 0, 15, 18, 18), tm_mk(1, 0, 24, 24, 24),
                    tm_mk(2, 0, 32, 32, 32));
      default:                   e = tm_mk(0, 0, 0, 0, 0);
    endcase
    return e;
  endfunction : tm_lookup

  // Which externally computed address time each form carries.
  function automatic tm_add_t tm_kind(input tm_op_t op, input tm_form_t f);
    tm_add_t k;
    k = ADD_NONE;
    if (op == OP_COMPARE_TO_ZERO) begin
      k = ADD_FETCH_EA;
    end else if (f[1]) begin
      if (op >= OP_FIELD_PROBE) begin
        k = ADD_CALC_IMM;
      end else if (op >= OP_SINGLE_BIT_PROBE && f == FORM_MEM_IMM) begin
        k = ADD_FETCH_IMM;
      end else if (op == OP_ZERO_OPERAND || op == OP_SET_ON_CONDITION ||
                   op == OP_TEST_AND_SET) begin
        k = ADD_CALC_EA;
      end else begin
        k = ADD_FETCH_EA;
      end
    end
    return k;
  endfunction : tm_kind

  function automatic logic f_is_reg_only(input tm_op_t op);
    return (op == OP_SIGN_WIDEN_OP) || (op == OP_DECIMAL_COMPLEMENT);
  endfunction : f_is_reg_only

  // ----------------------------------------------------------------------
  // Combinational selection
  // ----------------------------------------------------------------------
  tm_entry_t               ent;
  tm_add_t                 kind;
  tm_col_t                 col;
  logic                    bad;
  logic [TM_CNT_W-1:0]     col_total;
  logic [TM_TOT_W-1:0]     nxt_total;

  // Overlapped execution uses the best column, a cache hit the cache column,
  // and an external instruction fetch the worst column with its prefetch.
  always_comb begin
    col = i_overlapped ? COL_BEST : (i_icache_hit ? COL_CACHE : COL_WORST);
  end

  // Sign widening and decimal complement exist only on data registers; a
  // memory form there is flagged and timed as zero rather than guessed.
  always_comb begin
    bad  = f_is_reg_only(i_op) && i_form[1];
    ent  = bad ? tm_mk(0, 0, 0, 0, 0)
               : tm_lookup(i_op, i_form, tm_five_bytes(i_field_offset, i_field_width));
    kind = bad ? ADD_NONE : tm_kind(i_op, i_form);
    unique case (col)
      COL_BEST:  col_total = ent.best;
      COL_CACHE: col_total = ent.cache;
      COL_WORST: col_total = ent.worst;
      default:   col_total = ent.worst;
    endcase
    nxt_total = {{(TM_TOT_W-TM_CNT_W){1'b0}}, col_total} +
                ((kind == ADD_NONE) ? TM_TOT_W'(0) : {1'b0, i_ea_cycles});
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  tm_state_t             state_ff;
  logic [TM_TOT_W-1:0]   cnt_ff;
  logic                  take;

  assign take = i_start && (state_ff == ST_IDLE);

  // The triple is captured with the total so the two always agree; prefetch
  // is charged only in the worst column.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_total      <= '0;
      o_reads      <= '0;
      o_prefetches <= '0;
      o_writes     <= '0;
      o_add_kind   <= ADD_NONE;
      o_bad_form   <= 1'b0;
    end else if (take) begin
      o_total      <= nxt_total;
      o_reads      <= ent.rd;
      o_prefetches <= (col == COL_WORST && !bad) ? TM_WORST_PREFETCH : '0;
      o_writes     <= ent.wr;
      o_add_kind   <= kind;
      o_bad_form   <= bad;
    end
  end

  // Busy for exactly the total number of cycles, then one done pulse. A zero
  // total skips the busy phase and signals done on the next edge.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (take) begin
            if (nxt_total == '0) begin
              o_done <= 1'b1;
            end else begin
              state_ff <= ST_RUN;
              o_busy   <= 1'b1;
              cnt_ff   <= nxt_total - TM_TOT_W'(1);
            end
          end
        end
        ST_RUN: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_IDLE;
            o_busy   <= 1'b0;
            o_done   <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - TM_TOT_W'(1);
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_TRIPLE_INSIDE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_done |-> (o_total >= TM_TOT_W'(o_reads) + TM_TOT_W'(o_prefetches) +
                 TM_TOT_W'(o_writes)))
    else $error("Bus cycles exceed total.");

  AST_SHIFT_AMOUNT_FREE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_ARITH_SHIFT_LEFT && !i_form[1] && i_overlapped
    |=> o_total == 9'h005 && o_reads == 2'h0)
    else $error("Register shift time varies.");

  AST_FIELD_SPAN: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op >= OP_FIELD_PROBE && i_op <= OP_FIELD_FIND_FIRST_ONE && i_form[1]
    |=> o_reads == ($past(tm_five_bytes(i_field_offset, i_field_width)) ? 2'h2 : 2'h1))
    else $error("Field span cycles wrong.");

  AST_EA_ADDED: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && (i_op == OP_ARITH_INVERT_OP || i_op == OP_INVERT_WITH_CARRY_X)
    && i_form == FORM_MEM && i_overlapped
    |=> o_total == 9'h003 + {1'b0, $past(i_ea_cycles)} && o_add_kind == ADD_FETCH_EA)
    else $error("Fetch address time not added.");

  AST_IMM_CALC: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op >= OP_FIELD_PROBE && i_op <= OP_FIELD_FIND_FIRST_ONE && i_form[1]
    |=> o_add_kind == ADD_CALC_IMM)
    else $error("Field memory form lacks calc time.");

  AST_IMM_FETCH: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op >= OP_SINGLE_BIT_PROBE && i_op <= OP_SINGLE_BIT_FORCE_ONE
    && i_form == FORM_MEM_IMM
    |=> o_add_kind == ADD_FETCH_IMM)
    else $error("Immediate fetch time missing.");

  AST_TEST_SET_MEM: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_TEST_AND_SET && i_form == FORM_MEM && !i_overlapped && !i_icache_hit
    |=> (o_total == 9'h00d + {1'b0, $past(i_ea_cycles)} && o_prefetches == 2'h1
    && o_reads == 2'h1 && o_writes == 2'h1) ##1 o_busy [*8])
    else $error("Test and set timing wrong.");

  AST_ROX_CACHE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_ROTATE_THROUGH_X_LEFT && !i_form[1] && !i_overlapped && i_icache_hit
    |=> o_total == 9'h00c && o_reads == 2'h0 && o_writes == 2'h0)
    else $error("Rotate through x time wrong.");

  AST_BUSY_LENGTH: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_LOGIC_SHIFT_LEFT && i_form == FORM_REG_DYN && i_overlapped
    |=> o_busy [*3] ##1 (o_done && !o_busy))
    else $error("Dynamic shift not three cycles.");

  AST_PROBE_NO_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_SINGLE_BIT_PROBE && i_form == FORM_MEM && i_icache_hit
    |=> o_writes == 2'h0 && o_total == 9'h004 + {1'b0, $past(i_ea_cycles)})
    else $error("Bit probe timing wrong.");

  AST_FFO_FIVE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_FIELD_FIND_FIRST_ONE && i_form == FORM_MEM
    && tm_five_bytes(i_field_offset, i_field_width)
    |=> o_total == 9'h020 + {1'b0, $past(i_ea_cycles)} && o_reads == 2'h2)
    else $error("Find first one timing wrong.");

  AST_WORST_PREFETCH: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && !i_overlapped && !i_icache_hit && !bad |=> o_prefetches == 2'h1)
    else $error("Worst column lacks prefetch.");

  AST_BUSY_ENDS_DONE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(o_busy) |-> o_done)
    else $error("Busy ended without done.");

  AST_DEC_FLAT: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_DECIMAL_COMPLEMENT && !i_form[1]
    |=> o_total == 9'h006 && o_reads == 2'h0 && o_writes == 2'h0)
    else $error("Decimal complement time wrong.");

  AST_SHIFT_RIGHT_COLS: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_ARITH_SHIFT_RIGHT && !i_form[1]
    |=> o_total == ($past(i_overlapped) ? 9'h003 : 9'h006))
    else $error("Arithmetic right shift time wrong.");

  AST_TOGGLE_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_SINGLE_BIT_TOGGLE && i_form == FORM_MEM && i_overlapped
    |=> o_writes == 2'h1 && o_total == 9'h004 + {1'b0, $past(i_ea_cycles)})
    else $error("Bit toggle timing wrong.");

  AST_INSERT_FIVE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_FIELD_INSERT && i_form == FORM_MEM
    && tm_five_bytes(i_field_offset, i_field_width)
    |=> o_reads == 2'h2 && o_writes == 2'h2
    && o_total == ($past(i_overlapped || i_icache_hit) ? 9'h014 : 9'h015)
    + {1'b0, $past(i_ea_cycles)})
    else $error("Field insert timing wrong.");

  AST_EXTRACT_SHORT: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_FIELD_EXTRACT_UNSIGNED && i_form == FORM_MEM
    && !tm_five_bytes(i_field_offset, i_field_width)
    |=> o_reads == 2'h1 && o_total == 9'h00d + {1'b0, $past(i_ea_cycles)})
    else $error("Field extract timing wrong.");

  AST_COND_SET_MEM: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_SET_ON_CONDITION && i_form == FORM_MEM
    |=> o_writes == 2'h1 && o_total == 9'h006 + {1'b0, $past(i_ea_cycles)})
    else $error("Set on condition timing wrong.");

  AST_ROTATE_MEM: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_ROTATE_LEFT && i_form == FORM_MEM
    |=> o_writes == 2'h1 && o_total == 9'h007 + {1'b0, $past(i_ea_cycles)})
    else $error("Memory rotate timing wrong.");

  AST_WIDEN_COLS: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_SIGN_WIDEN_OP && !i_form[1]
    |=> o_total == ($past(i_overlapped) ? 9'h001 : 9'h004))
    else $error("Sign widen time wrong.");

  AST_INVERT_X_CACHE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_op == OP_INVERT_WITH_CARRY_X && i_form == FORM_MEM && !i_overlapped
    && i_icache_hit |=> o_writes == 2'h1 && o_total == 9'h004 + {1'b0, $past(i_ea_cycles)})
    else $error("Invert with carry time wrong.");

endmodule : tm_exec_timing

`default_nettype wire

// ---- tm_ea_source.sv ----
// Partner model: the address-time logic that feeds the timing unit.
// Assumes the bench raises i_valid in the cycle that offers a request.
`default_nettype none

module tm_ea_source (
  input  wire logic       i_sys_clk,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_cycles,
  output logic      [7:0] o_ea_cycles
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] churn_ff;

  // Outside a request the value changes every cycle, so a late sample cannot pass by luck.
  initial churn_ff = 8'ha5;
  always @(posedge i_sys_clk) begin
    churn_ff <= churn_ff + 8'h35;
  end

  assign o_ea_cycles = i_valid ? i_cycles : churn_ff;
endmodule : tm_ea_source

`default_nettype wire

// ---- tm_exec_timing_tb.sv ----
// Self-checking bench for the execution-timing unit.
// Assumes the timing unit answers on the taking edge, read at the falling edge after it.
`default_nettype none

module tm_exec_timing_tb;
  import tm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                i_sys_clk = 1'b0;
  logic                i_sys_rst = 1'b1;
  logic                i_start = 1'b0;
  tm_op_t              i_op = OP_ZERO_OPERAND;
  tm_form_t            i_form = FORM_REG_STATIC;
  logic                i_overlapped = 1'b0;
  logic                i_icache_hit = 1'b0;
  logic [2:0]          i_field_offset = 3'h0;
  logic [4:0]          i_field_width = 5'h0;
  logic [7:0]          i_ea_cycles;
  logic                o_busy, o_done, o_bad_form, ea_valid = 1'b0;
  logic [8:0]          o_total;
  logic [1:0]          o_reads, o_prefetches, o_writes;
  tm_add_t             o_add_kind;
  logic [7:0]          ea_req = 8'h0;
  logic [31:0]         seed = 32'h1b2a8c77;
  int                  errors = 0;
  int                  checked = 0;
  // Row: op, form, offset, width, reads, writes, best, cache, worst, added kind, bad form.
  int tbl[17][11] = '{'{7,2,0,0,1,1,12,12,13,2,0}, '{15,0,0,0,0,0,9,12,12,0,0},
    '{5,0,0,0,0,0,6,6,6,0,0}, '{9,1,0,0,0,0,3,6,6,0,0}, '{12,0,0,0,0,0,3,6,6,0,0},
    '{17,2,0,0,0,0,4,4,5,1,0}, '{18,2,0,0,0,1,4,4,5,1,0}, '{18,3,0,0,0,1,4,4,5,3,0},
    '{28,2,1,0,2,0,32,32,32,4,0}, '{27,2,4,30,2,2,20,20,21,4,0},
    '{26,2,0,0,1,0,13,13,13,4,0}, '{6,2,0,0,0,1,6,6,6,2,0}, '{13,2,0,0,0,1,7,7,7,1,0},
    '{4,0,0,0,0,0,1,4,4,0,0}, '{2,2,0,0,0,1,3,4,6,1,0}, '{4,2,0,0,0,0,0,0,0,0,1},
    '{11,1,0,0,0,0,5,8,8,0,0}};

  tm_exec_timing tm_exec_timing_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_start(i_start), .i_op(i_op), .i_form(i_form), .i_overlapped(i_overlapped),
    .i_icache_hit(i_icache_hit), .i_field_offset(i_field_offset),
    .i_field_width(i_field_width), .i_ea_cycles(i_ea_cycles), .o_busy(o_busy),
    .o_done(o_done), .o_bad_form(o_bad_form), .o_total(o_total), .o_reads(o_reads),
    .o_prefetches(o_prefetches), .o_writes(o_writes), .o_add_kind(o_add_kind));
  tm_ea_source tm_ea_source_i (.i_sys_clk(i_sys_clk), .i_valid(ea_valid),
    .i_cycles(ea_req), .o_ea_cycles(i_ea_cycles));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d.", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp

  // One operation in one column; a stray start during busy must be ignored.
  task automatic run(input int i, input int c);
    int n, k;
    logic [7:0] ea;
    ea = 8'(rnd());
    @(negedge i_sys_clk);
    i_start = 1'b1;
    i_op = tm_op_t'(tbl[i][0]);
    i_form = tm_form_t'(tbl[i][1]);
    i_field_offset = 3'(tbl[i][2]);
    i_field_width = 5'(tbl[i][3]);
    i_overlapped = (c == 0);
    i_icache_hit = (c == 1) || (c == 0 && ea[0]);
    ea_valid = 1'b1;
    ea_req = ea;
    n = tbl[i][6 + c] + ((tbl[i][9] != 0) ? int'(ea) : 0);
    @(negedge i_sys_clk);
    ea_valid = 1'b0;
    i_start = (n >= 3);
    i_op = OP_FIELD_FIND_FIRST_ONE;
    cmp("total", 9'(n), o_total);
    cmp("reads", 9'(tbl[i][4]), 9'(o_reads));
    cmp("prefetches", 9'(c == 2), 9'(o_prefetches));
    cmp("writes", 9'(tbl[i][5]), 9'(o_writes));
    cmp("bad form", 9'(tbl[i][10]), 9'(o_bad_form));
    cmp("add kind", 9'(tbl[i][9]), 9'(o_add_kind));
    k = 0;
    while (o_busy === 1'b1 && k < 600) begin
      k++;
      @(negedge i_sys_clk);
      i_start = 1'b0;
    end
    cmp("busy cycles", 9'(n), 9'(k));
    cmp("done", 9'h1, 9'(o_done));
    cmp("total held", 9'(n), o_total);
    if (k >= 600) print_verdict();
  endtask : run

  task automatic sweep(input int i);
    for (int c = 0; c < ((tbl[i][10] != 0) ? 1 : 3); c++) begin
      run(i, c);
    end
    $display("Test row %0d done, mismatches so far %0d.", i, errors);
  endtask : sweep

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(negedge i_sys_clk);
    cmp("busy in reset", 9'h0, 9'(o_busy));
    cmp("total in reset", 9'h0, o_total);
    i_sys_rst = 1'b0;
    sweep(0);
    sweep(1);
    sweep(2);
    sweep(3);
    sweep(4);
    sweep(5);
    sweep(6);
    sweep(7);
    sweep(8);
    sweep(9);
    sweep(10);
    sweep(11);
    sweep(12);
    sweep(13);
    sweep(14);
    sweep(15);
    sweep(16);
    // A reset in the middle of a long operation must clear it at once.
    @(negedge i_sys_clk);
    i_start = 1'b1;
    i_op = OP_FIELD_FIND_FIRST_ONE;
    i_form = FORM_REG_STATIC;
    i_overlapped = 1'b1;
    @(negedge i_sys_clk);
    i_start = 1'b0;
    cmp("busy before reset", 9'h1, 9'(o_busy));
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    cmp("busy after reset", 9'h0, 9'(o_busy));
    cmp("total after reset", 9'h0, o_total);
    cmp("done after reset", 9'h0, 9'(o_done));
    i_sys_rst = 1'b0;
    sweep(3);
    print_verdict();
  end
endmodule : tm_exec_timing_tb

`default_nettype wire
